// ===== core/lcs_pkg.sv
package lcs_pkg;
    // Port address and sub-addresses
    localparam logic [3:0] PORT_ADDR = 4'h1;
    localparam logic [2:0] MODE_CONTROL_ADDR = 3'h0;
    localparam logic [2:0] SIGNAL_CONTROL_ADDR = 3'h1;
    localparam logic [2:0] ADVANCED_TX_CONTROL_ONE_ADDR = 3'h2;
    localparam logic [2:0] ADVANCED_TX_CONTROL_ZERO_ADDR = 3'h3;
    localparam logic [2:0] RESERVED_PORT_REG_FOUR_ADDR = 3'h4;
    localparam logic [2:0] STATUS_MONITOR_ADDR = 3'h5;
    localparam logic [2:0] TRANSMIT_GAIN_ADDR = 3'h6;
    localparam logic [2:0] RESERVED_TEST_ADDR = 3'h7;
    // Field positions
    localparam int RX_POWER_DOWN_BIT = 6;
    localparam int TX_POWER_DOWN_BIT = 7;
    localparam int TIMING_MODE_LSB = 3;
    localparam int FLAT_GAIN_BIT = 2;
    localparam int TX_INV_BIT = 7;
    localparam int RX_INV_BIT = 6;
    localparam int ABSENT_OVR_BIT = 5;
    localparam int REMOTE_LB_BIT = 4;
    localparam int LOCAL_LB_BIT = 3;
    localparam int FIFO_RST_BIT = 0;
    localparam int TX_EQ_BIT = 0;
    localparam int BOOST_LSB = 1;
    localparam int FULL_LB_BIT = 0;
    localparam int RX_ABSENT_BIT = 4;
    localparam int TX_ABSENT_BIT = 1;
    localparam int FIFO_ERR_BIT = 0;
    // Reset values; timing mode bits come from the strap
    localparam logic [7:0] MODE_CONTROL_RST = 8'h01;
    localparam logic [7:0] SIGNAL_CONTROL_RST = 8'h00;
    localparam logic [7:0] ADV_ONE_RST = 8'h00;
    localparam logic [7:0] ADV_ZERO_RST = 8'ha8;
    localparam logic [7:0] RESERVED_FOUR_RST = 8'h80;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // Serial frame: 8 address bits then 8 data bits
    localparam logic [4:0] ADDR_BITS = 5'h08;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    typedef enum logic [1:0] {
        LCS_TM_RESERVED = 2'b00,
        LCS_TM_PLESIO = 2'b01,
        LCS_TM_SYNC = 2'b10,
        LCS_TM_LOOP = 2'b11
    } lcs_timing_t;
    typedef enum logic [1:0] {
        LCS_LVL_LOW,
        LCS_LVL_FLOAT,
        LCS_LVL_HIGH
    } lcs_level_t;
    typedef enum logic [1:0] {
        LCS_REF_19M44 = 2'b00,
        LCS_REF_77M76 = 2'b10,
        LCS_REF_155M52 = 2'b11
    } lcs_refclk_t;
endpackage

// ===== core/lcs_port_control.sv
// What this block does
// - Mode control bit 6 powers down the receive path; resets 0.
// - Timing mode field at bits 4:3 selects sync, plesio or loop.
// - Timing mode field resets to the strap pin level caught at reset.
// - Mode control bit 2 enables 20dB flat monitor gain.
// - Signal control bits 7 and 6 invert transmit and receive line polarity.
// - Loss override bit 5 holds loss output low and clears its counter.
// - Remote loopback bit 4 and local loopback bit 3 pick the loop path.
// - Writing 1 to FIFO pointer reset recentres the FIFO pointers.
// - Advanced control one bit 0 enables the transmit input equalizer.
// - Driver boost bits 2:1 select nominal, 5% or 10% amplitude.
// - Full digital loopback bit 0 loops decoded receive data to transmit.
// - Status bit 4 reports receive loss of signal.
// - Status bit 1 reports missing transmit input signal.
// - Status bit 0 sets on FIFO depth limit, clears on FIFO pointer reset.
// - Receive NRZ outputs are squelched low during loss of signal.
// - Transmit line outputs tri-state on register or pin power-down.
// - Hardware mode loopback pin: low normal, float remote, high local.
// - Timing mode pin: low reserved, float sync, high plesiochronous.
// - Hardware mode boost pin: low nominal, float 5%, high 10%.
// - Control select high uses serial registers, low uses strap pins.
// - Reference frequency strap is caught at reset release.
// - Port select low keeps serial output off and ignores clock and data.
// - Address and data move least significant bit first.
// - Input sampled on serial clock rise, output launched on fall.
// - Port numbers other than 1 are ignored as invalid.
`timescale 1ns/100ps
`default_nettype none
module lcs_port_control #(
    parameter int LOSS_COUNT = 16
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic softControlSelect,
    input wire logic txShutdownPin,
    input wire logic [1:0] loopbackPin,
    input wire logic [1:0] timingModePin,
    input wire logic [1:0] txEqPin,
    input wire logic [1:0] txBoostPin,
    input wire logic [1:0] refclkFreqPin,
    input wire logic flatGainPin,
    input wire logic rxLineIn,
    input wire logic rxLossRaw,
    input wire logic txInputAbsentRaw,
    input wire logic fifoDepthLimit,
    input wire logic rxNrzRaw,
    input wire logic txNrzRaw,
    input wire logic serialPortSelect,
    input wire logic serialClock,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOutEn,
    output logic rxPowerDown,
    output logic [1:0] timingModeSelect,
    output logic flatGainBoost,
    output logic rxLineInvOut,
    output logic txLineOut,
    output logic txLineOutEn,
    output logic rxNrzOut,
    output logic signalAbsentOut,
    output logic remoteLoopbackEn,
    output logic localLoopbackEn,
    output logic fullDigitalLoopbackEn,
    output logic fifoPointerReset,
    output logic txInputEqualizerEn,
    output logic [1:0] driverBoost,
    output logic [1:0] refclkFreqSel
);
    // Loss counter width is fixed at 8 bits
    if (LOSS_COUNT < 1 || LOSS_COUNT > 255) begin : g_bad_count
        $error("LOSS_COUNT out of range");
    end

    // ==========================================================
    // Synchronisers
    // Pins are foreign to sys_clk; all but rxLineIn, rxNrzRaw and txNrzRaw pass two flops before any use.
    localparam int NSYNC = 19;
    logic [NSYNC-1:0] pinRaw;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    assign pinRaw = {softControlSelect, txShutdownPin, loopbackPin,
        timingModePin, txEqPin, txBoostPin, refclkFreqPin, flatGainPin,
        rxLossRaw, txInputAbsentRaw, fifoDepthLimit, serialPortSelect,
        serialClock, serialDataIn};
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pinRaw;
            sync2_r <= sync1_r;
        end
    end
    logic swMode, txShut, gainPin, rxLoss, txAbsent, fifoLimit;
    logic selSync, sckSync, sdiSync;
    logic [1:0] lbPin, tmPin, eqPin, bstPin, refPin;
    assign {swMode, txShut, lbPin, tmPin, eqPin, bstPin, refPin, gainPin,
        rxLoss, txAbsent, fifoLimit, selSync, sckSync, sdiSync} = sync2_r;

    function automatic lcs_pkg::lcs_level_t lvl(input logic [1:0] p);
        if (p == 2'b00) begin
            lvl = lcs_pkg::LCS_LVL_LOW;
        end else if (p == 2'b11) begin
            lvl = lcs_pkg::LCS_LVL_HIGH;
        end else begin
            lvl = lcs_pkg::LCS_LVL_FLOAT;
        end
    endfunction

    // ==========================================================
    // Strap capture
    // Reloaded until the synchronisers carry true pin levels.
    logic [1:0] strapCnt_r;
    logic [1:0] refSel_r;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            strapCnt_r <= 2'h0;
            refSel_r <= lcs_pkg::LCS_REF_19M44;
        end else if (strapCnt_r != 2'h3) begin
            strapCnt_r <= strapCnt_r + 2'h1;
            case (lvl(refPin))
                lcs_pkg::LCS_LVL_LOW: refSel_r <= lcs_pkg::LCS_REF_19M44;
                lcs_pkg::LCS_LVL_FLOAT: refSel_r <= lcs_pkg::LCS_REF_77M76;
                default: refSel_r <= lcs_pkg::LCS_REF_155M52;
            endcase
        end
    end

    function automatic logic [1:0] tmFromPin(input logic [1:0] p);
        case (lvl(p))
            lcs_pkg::LCS_LVL_FLOAT: tmFromPin = lcs_pkg::LCS_TM_SYNC;
            lcs_pkg::LCS_LVL_HIGH: tmFromPin = lcs_pkg::LCS_TM_PLESIO;
            default: tmFromPin = lcs_pkg::LCS_TM_RESERVED;
        endcase
    endfunction

    // ==========================================================
    // Serial port
    logic sckPrev_r;
    logic [4:0] bitCnt_r;
    logic [7:0] addr_r, wdata_r, rdata_r;
    logic wrStrobe_r, rdStrobe_r;
    logic sckRise, sckFall, addrValid;
    assign sckRise = sckSync && !sckPrev_r;
    assign sckFall = !sckSync && sckPrev_r;
    assign addrValid = (addr_r[7:4] == lcs_pkg::PORT_ADDR);

    logic [7:0] modeCtl_r, sigCtl_r, advOne_r, advZero_r, status_r;

    function automatic logic [7:0] readMux(input logic [2:0] sa,
        input logic [7:0] m, input logic [7:0] s, input logic [7:0] a1,
        input logic [7:0] a0, input logic [7:0] st);
        if (sa == lcs_pkg::MODE_CONTROL_ADDR) begin
            readMux = m;
        end else if (sa == lcs_pkg::SIGNAL_CONTROL_ADDR) begin
            readMux = s;
        end else if (sa == lcs_pkg::ADVANCED_TX_CONTROL_ONE_ADDR) begin
            readMux = a1;
        end else if (sa == lcs_pkg::ADVANCED_TX_CONTROL_ZERO_ADDR) begin
            readMux = a0;
        end else if (sa == lcs_pkg::RESERVED_PORT_REG_FOUR_ADDR) begin
            readMux = lcs_pkg::RESERVED_FOUR_RST;
        end else if (sa == lcs_pkg::STATUS_MONITOR_ADDR) begin
            readMux = st;
        end else begin
            readMux = lcs_pkg::ZERO_BYTE;
        end
    endfunction

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sckPrev_r <= 1'b0;
            bitCnt_r <= '0;
            addr_r <= '0;
            wdata_r <= '0;
            rdata_r <= '0;
            wrStrobe_r <= 1'b0;
            rdStrobe_r <= 1'b0;
            serialDataOut <= 1'b0;
            serialDataOutEn <= 1'b0;
        end else begin
            sckPrev_r <= sckSync;
            wrStrobe_r <= 1'b0;
            rdStrobe_r <= 1'b0;
            if (!selSync || !swMode) begin
                bitCnt_r <= '0;
                serialDataOutEn <= 1'b0;
                serialDataOut <= 1'b0;
            end else if (sckRise && bitCnt_r < lcs_pkg::FRAME_BITS) begin
                bitCnt_r <= bitCnt_r + 5'h01;
                if (bitCnt_r < lcs_pkg::ADDR_BITS) begin
                    addr_r <= {sdiSync, addr_r[7:1]};
                end else begin
                    wdata_r <= {sdiSync, wdata_r[7:1]};
                end
                if (bitCnt_r == lcs_pkg::ADDR_BITS - 5'h01) begin
                    // Port bits 6:4 sit in addr_r[7:5]; bit 7 is on the pin
                    if (addr_r[1] && addr_r[7:5] == 3'h1 && !sdiSync) begin
                        rdata_r <= readMux(addr_r[4:2], modeCtl_r, sigCtl_r,
                            advOne_r, advZero_r, status_r);
                        rdStrobe_r <= (addr_r[4:2] ==
                            lcs_pkg::STATUS_MONITOR_ADDR);
                    end
                end
                if (bitCnt_r == lcs_pkg::FRAME_BITS - 5'h01 &&
                    !addr_r[0] && addrValid) begin
                    wrStrobe_r <= 1'b1;
                end
            end else if (sckFall && bitCnt_r >= lcs_pkg::ADDR_BITS &&
                addr_r[0] && addrValid) begin
                serialDataOutEn <= 1'b1;
                serialDataOut <= rdata_r[0];
                rdata_r <= {1'b0, rdata_r[7:1]};
            end
        end
    end

    // ==========================================================
    // Control registers
    // Reserved fields keep defaults; only named bits take writes.
    logic [2:0] wsa;
    assign wsa = addr_r[3:1];
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            modeCtl_r <= lcs_pkg::MODE_CONTROL_RST;
            sigCtl_r <= lcs_pkg::SIGNAL_CONTROL_RST;
            advOne_r <= lcs_pkg::ADV_ONE_RST;
            advZero_r <= lcs_pkg::ADV_ZERO_RST;
        end else begin
            sigCtl_r[lcs_pkg::FIFO_RST_BIT] <= 1'b0;
            if (strapCnt_r != 2'h3) begin
                modeCtl_r[lcs_pkg::TIMING_MODE_LSB +: 2] <=
                    tmFromPin(tmPin);
            end else if (wrStrobe_r) begin
                if (wsa == lcs_pkg::MODE_CONTROL_ADDR) begin
                    modeCtl_r[7:6] <= wdata_r[7:6];
                    modeCtl_r[4:2] <= wdata_r[4:2];
                end else if (wsa == lcs_pkg::SIGNAL_CONTROL_ADDR) begin
                    sigCtl_r[7:3] <= wdata_r[7:3];
                    sigCtl_r[0] <= wdata_r[0];
                end else if (wsa ==
                    lcs_pkg::ADVANCED_TX_CONTROL_ONE_ADDR) begin
                    advOne_r[0] <= wdata_r[0];
                end else if (wsa ==
                    lcs_pkg::ADVANCED_TX_CONTROL_ZERO_ADDR) begin
                    advZero_r[2:0] <= wdata_r[2:0];
                end
            end
        end
    end

    // ==========================================================
    // Status flags
    // Set wins over read-clear; a one-cycle event set on the edge the read samples status is cleared unread.
    logic [7:0] lossCnt_r;
    logic lossDet_r;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            lossCnt_r <= '0;
            lossDet_r <= 1'b0;
        end else if (!rxLoss ||
            (sigCtl_r[lcs_pkg::ABSENT_OVR_BIT] && swMode)) begin
            lossCnt_r <= '0;
            lossDet_r <= 1'b0;
        end else if (lossCnt_r == 8'(LOSS_COUNT - 1)) begin
            lossDet_r <= 1'b1;
        end else begin
            lossCnt_r <= lossCnt_r + 8'h01;
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            status_r <= '0;
        end else begin
            if (rdStrobe_r) begin
                status_r <= '0;
            end
            if (lossDet_r) begin
                status_r[lcs_pkg::RX_ABSENT_BIT] <= 1'b1;
            end
            if (txAbsent) begin
                status_r[lcs_pkg::TX_ABSENT_BIT] <= 1'b1;
            end
            if (fifoPointerReset) begin
                status_r[lcs_pkg::FIFO_ERR_BIT] <= 1'b0;
            end else if (fifoLimit) begin
                status_r[lcs_pkg::FIFO_ERR_BIT] <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Effective controls
    // Hardware mode takes straps; no serial write can reach them.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rxPowerDown <= 1'b0;
            timingModeSelect <= lcs_pkg::LCS_TM_RESERVED;
            flatGainBoost <= 1'b0;
            rxLineInvOut <= 1'b0;
            txLineOut <= 1'b0;
            txLineOutEn <= 1'b0;
            rxNrzOut <= 1'b0;
            signalAbsentOut <= 1'b0;
            remoteLoopbackEn <= 1'b0;
            localLoopbackEn <= 1'b0;
            fullDigitalLoopbackEn <= 1'b0;
            fifoPointerReset <= 1'b0;
            txInputEqualizerEn <= 1'b0;
            driverBoost <= 2'b00;
            refclkFreqSel <= lcs_pkg::LCS_REF_19M44;
        end else begin
            refclkFreqSel <= refSel_r;
            signalAbsentOut <= lossDet_r;
            rxNrzOut <= lossDet_r ? 1'b0 : rxNrzRaw;
            fifoPointerReset <= sigCtl_r[lcs_pkg::FIFO_RST_BIT] && swMode;
            if (swMode) begin
                rxPowerDown <= modeCtl_r[lcs_pkg::RX_POWER_DOWN_BIT];
                timingModeSelect <=
                    modeCtl_r[lcs_pkg::TIMING_MODE_LSB +: 2];
                flatGainBoost <= modeCtl_r[lcs_pkg::FLAT_GAIN_BIT];
                rxLineInvOut <= rxLineIn ^ sigCtl_r[lcs_pkg::RX_INV_BIT];
                txLineOut <= txNrzRaw ^ sigCtl_r[lcs_pkg::TX_INV_BIT];
                txLineOutEn <= !(txShut ||
                    modeCtl_r[lcs_pkg::TX_POWER_DOWN_BIT]);
                remoteLoopbackEn <= sigCtl_r[lcs_pkg::REMOTE_LB_BIT] &&
                    !sigCtl_r[lcs_pkg::LOCAL_LB_BIT];
                localLoopbackEn <= sigCtl_r[lcs_pkg::LOCAL_LB_BIT] &&
                    !sigCtl_r[lcs_pkg::REMOTE_LB_BIT];
                fullDigitalLoopbackEn <= advZero_r[lcs_pkg::FULL_LB_BIT];
                txInputEqualizerEn <= advOne_r[lcs_pkg::TX_EQ_BIT];
                driverBoost <= advZero_r[lcs_pkg::BOOST_LSB +: 2];
            end else begin
                rxPowerDown <= 1'b0;
                timingModeSelect <= tmFromPin(tmPin);
                flatGainBoost <= gainPin;
                rxLineInvOut <= rxLineIn;
                txLineOut <= txNrzRaw;
                txLineOutEn <= !txShut;
                remoteLoopbackEn <=
                    (lvl(lbPin) == lcs_pkg::LCS_LVL_FLOAT);
                localLoopbackEn <=
                    (lvl(lbPin) == lcs_pkg::LCS_LVL_HIGH);
                fullDigitalLoopbackEn <= 1'b0;
                txInputEqualizerEn <= (lvl(eqPin) == lcs_pkg::LCS_LVL_LOW);
                case (lvl(bstPin))
                    lcs_pkg::LCS_LVL_LOW: driverBoost <= 2'b00;
                    lcs_pkg::LCS_LVL_FLOAT: driverBoost <= 2'b01;
                    default: driverBoost <= 2'b11;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ===== sim/lcs_port_control_props.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// Port behaviour checker
module lcs_port_control_props #(
    parameter int LOSS_COUNT = 16
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic softControlSelect,
    input wire logic txShutdownPin,
    input wire logic [1:0] loopbackPin,
    input wire logic [1:0] txBoostPin,
    input wire logic serialPortSelect,
    input wire logic serialClock,
    input wire logic serialDataOut,
    input wire logic serialDataOutEn,
    input wire logic rxPowerDown,
    input wire logic txLineOutEn,
    input wire logic rxNrzOut,
    input wire logic signalAbsentOut,
    input wire logic remoteLoopbackEn,
    input wire logic localLoopbackEn,
    input wire logic fullDigitalLoopbackEn,
    input wire logic fifoPointerReset,
    input wire logic [1:0] driverBoost,
    input wire logic [1:0] refclkFreqSel
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    // Straps move while synchronisers fill, so freeze only after settling
    logic [3:0] settleCnt_r;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            settleCnt_r <= 4'h0;
        end else if (settleCnt_r != 4'hf) begin
            settleCnt_r <= settleCnt_r + 4'h1;
        end
    end
    refclk_hold_a:
        assert property (settleCnt_r == 4'hf |-> $stable(refclkFreqSel))
        else $error("reference select moved after reset");
    squelch_low_a:
        assert property (signalAbsentOut [*3] |-> !rxNrzOut)
        else $error("rx data not squelched");
    pin_shutdown_a:
        assert property (txShutdownPin [*5] |-> !txLineOutEn)
        else $error("tx line driven during shutdown");
    deselect_quiet_a:
        assert property (!serialPortSelect [*5] |-> !serialDataOutEn)
        else $error("serial output driven while deselected");
    launch_on_fall_a:
        assert property (serialDataOutEn && $changed(serialDataOut)
            |-> !serialClock)
        else $error("serial output moved while clock high");
    hw_local_a:
        assert property ((!softControlSelect && loopbackPin == 2'b11) [*6]
            |-> localLoopbackEn && !remoteLoopbackEn)
        else $error("strap local loopback wrong");
    hw_boost_a:
        assert property ((!softControlSelect && txBoostPin == 2'b11) [*6]
            |-> driverBoost == 2'b11)
        else $error("strap boost wrong");
    hw_defaults_a:
        assert property (!softControlSelect [*6]
            |-> !rxPowerDown && !fullDigitalLoopbackEn)
        else $error("register setting leaks into strap mode");
    fifo_pointer_reset_pulse_a:
        assert property (fifoPointerReset |=> !fifoPointerReset)
        else $error("fifo reset not self clearing");
endmodule
bind lcs_port_control lcs_port_control_props
    #(.LOSS_COUNT(LOSS_COUNT)) i_props (
    .sys_clk, .nrst, .softControlSelect, .txShutdownPin, .loopbackPin,
    .txBoostPin, .serialPortSelect, .serialClock, .serialDataOut,
    .serialDataOutEn, .rxPowerDown, .txLineOutEn, .rxNrzOut,
    .signalAbsentOut, .remoteLoopbackEn, .localLoopbackEn,
    .fullDigitalLoopbackEn, .fifoPointerReset, .driverBoost, .refclkFreqSel
);
`default_nettype wire

// ===== sim/lcs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// Serial host
module lcs_host_model (
    output logic serialPortSelect,
    output logic serialClock,
    output logic serialDataIn,
    input wire logic serialDataOut
);
    initial begin
        serialPortSelect = 1'b0;
        serialClock = 1'b0;
        serialDataIn = 1'b0;
    end
    // Clock parks low between frames; short n drops the write
    task automatic frame(input logic [15:0] bits, input int n,
                         output logic [7:0] rd);
        rd = 8'h00;
        #3.0;
        serialPortSelect = 1'b1;
        for (int i = 0; i < n; i++) begin
            serialDataIn = bits[i];
            #62.5;
            serialClock = 1'b1;
            if (i >= 8) begin
                rd[i - 8] = serialDataOut;
            end
            #62.5;
            serialClock = 1'b0;
        end
        serialDataIn = ~serialDataIn;
        #62.5;
        serialPortSelect = 1'b0;
        #250;
    endtask
endmodule
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// Port control bench
module tb;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic softControlSelect = 1'b1;
    logic txShutdownPin = 1'b0;
    logic [1:0] loopbackPin = 2'b00;
    logic [1:0] timingModePin = 2'b01;
    logic [1:0] txEqPin = 2'b01;
    logic [1:0] txBoostPin = 2'b00;
    logic [1:0] refclkFreqPin = 2'b11;
    logic flatGainPin = 1'b0;
    logic rxLineIn = 1'b1;
    logic rxLossRaw = 1'b0;
    logic txInputAbsentRaw = 1'b0;
    logic fifoDepthLimit = 1'b0;
    logic rxNrzRaw = 1'b1;
    logic txNrzRaw = 1'b0;
    logic serialPortSelect, serialClock, serialDataIn, serialDataOut;
    logic serialDataOutEn, rxPowerDown, flatGainBoost, rxLineInvOut;
    logic txLineOut, txLineOutEn, rxNrzOut, signalAbsentOut;
    logic remoteLoopbackEn, localLoopbackEn, fullDigitalLoopbackEn;
    logic fifoPointerReset, txInputEqualizerEn;
    logic [1:0] timingModeSelect, driverBoost, refclkFreqSel;
    logic oeSeen = 1'b0;
    logic frstSeen = 1'b0;
    logic [16:0] lfsr_r = 17'h10a90;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    lcs_port_control #(.LOSS_COUNT(2)) i_lcs_port_control (
        .sys_clk, .nrst, .softControlSelect, .txShutdownPin, .loopbackPin,
        .timingModePin, .txEqPin, .txBoostPin, .refclkFreqPin, .flatGainPin,
        .rxLineIn, .rxLossRaw, .txInputAbsentRaw, .fifoDepthLimit, .rxNrzRaw,
        .txNrzRaw, .serialPortSelect, .serialClock, .serialDataIn,
        .serialDataOut, .serialDataOutEn, .rxPowerDown, .timingModeSelect,
        .flatGainBoost, .rxLineInvOut, .txLineOut, .txLineOutEn, .rxNrzOut,
        .signalAbsentOut, .remoteLoopbackEn, .localLoopbackEn,
        .fullDigitalLoopbackEn, .fifoPointerReset, .txInputEqualizerEn,
        .driverBoost, .refclkFreqSel
    );
    lcs_host_model i_host (.serialPortSelect, .serialClock, .serialDataIn,
        .serialDataOut);
    always #5 sys_clk = ~sys_clk;
    task automatic complete_run();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (serialDataOutEn === 1'b1) oeSeen = 1'b1;
        if (fifoPointerReset === 1'b1) frstSeen = 1'b1;
        if (cycles == 40000) begin
            mismatches++;
            complete_run();
        end
    end
    function automatic logic [16:0] lfsrNext(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    // Readback after a write: reserved bits keep defaults
    function automatic logic [7:0] regExp(input logic [2:0] sub,
                                          input logic [7:0] d);
        case (sub)
            3'h0: return (d & 8'hdc) | 8'h01;
            3'h1: return d & 8'hf8;
            3'h2: return d & 8'h01;
            3'h3: return (d & 8'h07) | 8'ha8;
            3'h4: return 8'h80;
            default: return 8'h00;
        endcase
    endfunction
    task automatic rnd(output logic [7:0] v);
        lfsr_r = lfsrNext(lfsr_r);
        v = lfsr_r[7:0];
    endtask
    task automatic chk(input string what, input logic [7:0] want,
                       input logic [7:0] got);
        checked++;
        if (got !== want) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, want, got);
        end
    endtask
    task automatic wr(input logic [3:0] port, input logic [2:0] sub,
                      input logic [7:0] d, input int n);
        logic [7:0] rd;
        i_host.frame({d, port, sub, 1'b0}, n, rd);
        repeat (4) @(negedge sys_clk);
    endtask
    task automatic rdchk(input logic [2:0] sub, input logic [7:0] want);
        logic [7:0] rd;
        i_host.frame({8'h00, 4'h1, sub, 1'b1}, 16, rd);
        repeat (4) @(negedge sys_clk);
        chk("register read", want, rd);
    endtask
    initial begin
        logic [7:0] d;
        logic [7:0] o;
        logic [7:0] e;
        logic [1:0] lv;
        repeat (6) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (6) @(negedge sys_clk);
        rdchk(3'h0, 8'h11);
        for (int s = 1; s < 8; s++)
            rdchk(3'(s), regExp(3'(s), 8'h00));
        o = {4'h0, timingModeSelect, refclkFreqSel};
        chk("straps", 8'h0b, o);
        for (int m = 0; m < 4; m++) begin
            rnd(d);
            d[4:3] = 2'(m);
            wr(4'h1, 3'h0, d, 16);
            rdchk(3'h0, regExp(3'h0, d));
            o = {3'h0, txLineOutEn, rxPowerDown, flatGainBoost,
                 timingModeSelect};
            chk("mode", {3'h0, ~d[7], d[6], d[2], d[4:3]}, o);
        end
        wr(4'h1, 3'h0, 8'h10, 16);
        for (int m = 0; m < 4; m++) begin
            rnd(d);
            d[4:3] = 2'(m);
            wr(4'h1, 3'h1, d, 16);
            rdchk(3'h1, regExp(3'h1, d));
            o = {4'h0, txLineOut, remoteLoopbackEn, localLoopbackEn,
                 rxLineInvOut};
            e = {4'h0, d[7], d[4] & ~d[3], d[3] & ~d[4], ~d[6]};
            chk("loops", e, o);
        end
        wr(4'h1, 3'h1, 8'h20, 16);
        rxLossRaw = 1'b1;
        repeat (12) @(negedge sys_clk);
        chk("loss override", 8'h00, {7'h0, signalAbsentOut});
        wr(4'h1, 3'h1, 8'h00, 16);
        chk("squelch", 8'h02, {6'h0, signalAbsentOut, rxNrzOut});
        rxLossRaw = 1'b0;
        txInputAbsentRaw = 1'b1;
        fifoDepthLimit = 1'b1;
        repeat (8) @(negedge sys_clk);
        chk("loss ended", 8'h01, {6'h0, signalAbsentOut, rxNrzOut});
        txInputAbsentRaw = 1'b0;
        fifoDepthLimit = 1'b0;
        repeat (4) @(negedge sys_clk);
        rdchk(3'h5, 8'h13);
        rdchk(3'h5, 8'h00);
        fifoDepthLimit = 1'b1;
        repeat (6) @(negedge sys_clk);
        fifoDepthLimit = 1'b0;
        frstSeen = 1'b0;
        wr(4'h1, 3'h1, 8'h01, 16);
        chk("fifo reset", 8'h01, {7'h0, frstSeen});
        rdchk(3'h5, 8'h00);
        for (int b = 0; b < 4; b++) begin
            rnd(d);
            d[2:1] = 2'(b);
            wr(4'h1, 3'h2, d, 16);
            wr(4'h1, 3'h3, d, 16);
            rdchk(3'h2, regExp(3'h2, d));
            rdchk(3'h3, regExp(3'h3, d));
            o = {4'h0, driverBoost, fullDigitalLoopbackEn,
                 txInputEqualizerEn};
            chk("adv", {4'h0, d[2:0], d[0]}, o);
        end
        for (int s = 4; s < 8; s++) begin
            wr(4'h1, 3'(s), 8'hff, 16);
            rdchk(3'(s), regExp(3'(s), 8'hff));
        end
        wr(4'h2, 3'h0, 8'hff, 16);
        wr(4'h1, 3'h0, 8'hff, 12);
        rdchk(3'h0, 8'h11);
        oeSeen = 1'b0;
        i_host.frame({8'h00, 4'h2, 3'h0, 1'b1}, 16, d);
        chk("invalid read", 8'h00, {7'h0, oeSeen});
        txShutdownPin = 1'b1;
        refclkFreqPin = 2'b00;
        repeat (8) @(negedge sys_clk);
        o = {5'h0, ~txLineOutEn, refclkFreqSel};
        chk("shutdown", 8'h07, o);
        txShutdownPin = 1'b0;
        softControlSelect = 1'b0;
        for (int l = 0; l < 4; l++) begin
            lv = 2'(l ^ (l >> 1));
            loopbackPin = lv;
            txBoostPin = lv;
            repeat (8) @(negedge sys_clk);
            e = {2'h0, ^lv, &lv, (^lv) ? 2'b01 : lv, 2'b00};
            o = {2'h0, remoteLoopbackEn, localLoopbackEn, driverBoost,
                 rxPowerDown, fullDigitalLoopbackEn};
            chk("hw straps", e, o);
        end
        complete_run();
    end
endmodule
`default_nettype wire
